// ### verilog/nvm_page_program_controller.sv
/*
 NVM page program controller: page buffer, section protection, command
 sequencer and AXI4-Lite register slave. Assumes the arrays follow the
 arr_* strobes and that fuse inputs are stable while reset is released.
*/
module nvm_page_program_controller
  import nvm_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite register slave
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [11:0]           awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [11:0]           araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  // Origin of accesses
  input  wire logic                  bus_from_debug,
  input  wire logic                  mem_from_debug,
  input  wire logic                  device_locked,
  // CPU memory port
  input  wire logic [15:0]           cpu_pc,
  input  wire logic                  cpu_instr_done,
  input  wire logic                  mem_valid,
  input  wire logic                  mem_write,
  input  wire logic [15:0]           mem_addr,
  input  wire logic [7:0]            mem_wdata,
  output logic [7:0]                 mem_rdata,
  output logic                       mem_wait,
  output logic                       fetch_blocked,
  output logic                       cpu_halt,
  input  wire logic                  wake_up,
  // Fuses
  input  wire logic [7:0]            boot_end_fuse,
  input  wire logic [7:0]            app_code_end_fuse,
  input  wire logic                  eeprom_keep_on_erase,
  // Array side
  input  wire logic [7:0]            arr_rdata,
  output logic                       arr_active,
  output logic                       arr_start,
  output logic                       arr_erase,
  output logic                       arr_program,
  output logic                       arr_whole,
  output logic                       arr_keep_ee,
  output logic [1:0]                 arr_target,
  output logic [15:0]                arr_page,
  output logic [8*PB_BYTES-1:0]      arr_data,
  output logic [PB_BYTES-1:0]        arr_mark,
  output logic                       fuse_wr_strobe,
  output logic [15:0]                fuse_wr_addr,
  output logic [7:0]                 fuse_wr_data
);

  logic [7:0]          boot_end_q;
  logic [7:0]          app_end_q;
  logic                ee_keep_q;
  logic                fuse_ld_q;
  logic                app_code_write_protect_q;
  logic                block_q;
  logic                wrerr_q;
  logic [2:0]          cmd_q;
  logic [2:0]          win_q;
  logic [15:0]         addr_q;
  logic [15:0]         data_q;
  state_e              state_q;
  tgt_e                tgt_q;
  logic                erw_q;
  logic [15:0]         timer_q;
  logic                pb_clr;
  logic [7:0]          pb_q [PB_BYTES];
  logic [PB_BYTES-1:0] mark_q;
  logic [1:0]          reg_q;
  logic [15:0]         page_q;
  logic                aw_q;
  logic                w_q;
  logic [11:0]         awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;

  // Fuses are taken once after reset so a new value needs a reset to act
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_ld_q  <= 1'b0;
      boot_end_q <= 8'h00;
      app_end_q  <= 8'h00;
      ee_keep_q  <= 1'b0;
    end else if (!fuse_ld_q) begin
      fuse_ld_q  <= 1'b1;
      boot_end_q <= boot_end_fuse;
      app_end_q  <= app_code_end_fuse;
      ee_keep_q  <= eeprom_keep_on_erase;
    end
  end

  function automatic sect_e sect_of(input logic [15:0] a);
    logic [15:0] blk;
    blk = (a - FLASH_BASE) >> BLOCK_SH;
    if (boot_end_q == 8'h00 && app_end_q == 8'h00) begin
      sect_of = SEC_BOOT;
    end else if (blk < {8'h00, boot_end_q}) begin
      sect_of = SEC_BOOT;
    end else if (app_end_q == 8'h00 || blk < {8'h00, app_end_q}) begin
      sect_of = SEC_CODE;
    end else begin
      sect_of = SEC_DATA;
    end
  endfunction

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] b,
                                  input logic [15:0] s);
    in_rng = (a >= b) && ((a - b) < s);
  endfunction

  logic  busy;
  logic  t_flash;
  logic  t_ee;
  logic  t_user;
  logic  pc_boot;
  sect_e exec_sec;
  sect_e tsec;
  logic  store_ok;
  logic  store_en;
  logic  load_en;
  logic  [1:0] t_reg;

  assign busy     = state_q != ST_IDLE;
  assign t_flash  = in_rng(mem_addr, FLASH_BASE, FLASH_SIZE);
  assign t_ee     = in_rng(mem_addr, EE_BASE, EE_SIZE);
  assign t_user   = in_rng(mem_addr, USER_BASE, USER_SIZE);
  assign exec_sec = sect_of(cpu_pc);
  assign tsec     = sect_of(mem_addr);
  assign pc_boot  = exec_sec == SEC_BOOT;
  assign t_reg    = t_flash ? 2'(TGT_FLASH) : (t_ee ? 2'(TGT_EE) : 2'(TGT_USER));

  // Loads and stores wait out a running operation; stores too, so an
  // EEPROM page being programmed is never altered under the array
  assign mem_wait = mem_valid && busy && (t_flash || t_ee || t_user);
  assign load_en  = mem_valid && !mem_write && !mem_wait;

  always_comb begin
    store_ok = 1'b0;
    if (mem_from_debug) begin
      if (device_locked) begin
        store_ok = t_user;
      end else if (t_flash) begin
        store_ok = !(tsec == SEC_BOOT && block_q) &&
                   !(tsec == SEC_CODE && app_code_write_protect_q);
      end else begin
        store_ok = t_ee || t_user;
      end
    end else if (exec_sec == SEC_DATA) begin
      store_ok = 1'b0;
    end else if (t_flash) begin
      if (tsec == SEC_BOOT) begin
        store_ok = 1'b0;
      end else if (tsec == SEC_CODE) begin
        store_ok = pc_boot && !app_code_write_protect_q;
      end else begin
        store_ok = 1'b1;
      end
    end else begin
      store_ok = t_ee || t_user;
    end
    if (mark_q != '0 && reg_q != t_reg) begin
      store_ok = 1'b0;
    end
  end

  assign store_en = mem_valid && mem_write && !mem_wait &&
                    (t_flash || t_ee || t_user) && store_ok;

  // Lock hides the boot section from loads and fetches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_rdata     <= 8'h00;
      fetch_blocked <= 1'b0;
    end else begin
      fetch_blocked <= block_q && pc_boot;
      if (load_en) begin
        if (t_flash && tsec == SEC_BOOT && block_q) begin
          mem_rdata <= 8'h00;
        end else begin
          mem_rdata <= arr_rdata;
        end
      end
    end
  end

  // One buffer for all three ranges; the address of the last store picks
  // the page, so mixing ranges before a command is refused
  genvar gi;
  generate
    for (gi = 0; gi < PB_BYTES; gi++) begin : g_pb
      always_ff @(posedge aclk) begin
        if (!aresetn || pb_clr || wake_up) begin
          pb_q[gi]   <= 8'hFF;
          mark_q[gi] <= 1'b0;
        end else if (store_en && mem_addr[PB_W-1:0] == PB_W'(gi)) begin
          pb_q[gi]   <= pb_q[gi] & mem_wdata;
          mark_q[gi] <= 1'b1;
        end
      end
      assign arr_data[8*gi +: 8] = pb_q[gi];
    end
  endgenerate

  assign arr_mark = mark_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_q  <= 2'(TGT_FLASH);
      page_q <= 16'h0000;
    end else if (store_en) begin
      reg_q  <= t_reg;
      page_q <= mem_addr >> PB_W;
    end
  end

  // Register write path
  logic        wr_go;
  logic [7:0]  wr_idx;
  logic        wr_map;
  logic        key_wr;
  logic        ctrla_wr;
  logic        cmd_ok;
  logic [2:0]  new_cmd;

  assign wr_go    = aw_q && w_q && !bvalid;
  assign wr_idx   = awaddr_q[9:2];
  assign wr_map   = awaddr_q[11:10] == 2'h0;
  assign new_cmd  = wdata_q[2:0];
  assign key_wr   = wr_go && wr_map && wr_idx == IDX_KEY && wstrb_q[0];
  assign ctrla_wr = wr_go && wr_map && wr_idx == IDX_CTRLA && wstrb_q[0];
  assign cmd_ok   = ctrla_wr && !busy &&
                    (bus_from_debug || win_q != 3'h0);

  // Unlock window counts retired instructions
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrla_wr) begin
      win_q <= 3'h0;
    end else if (key_wr && wdata_q[7:0] == UNLOCK_KEY) begin
      win_q <= KEY_WINDOW;
    end else if (cpu_instr_done && win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      app_code_write_protect_q <= 1'b0;
      block_q <= 1'b0;
      addr_q  <= 16'h0000;
      data_q  <= 16'h0000;
    end else if (wr_go && wr_map) begin
      if (wr_idx == IDX_CTRLB && wstrb_q[0]) begin
        app_code_write_protect_q <= app_code_write_protect_q | wdata_q[CB_APP_CODE_WRITE_PROTECT];
        if (pc_boot || bus_from_debug) begin
          block_q <= block_q | wdata_q[CB_BLOCK];
        end
      end else if (wr_idx == IDX_ADDR) begin
        if (wstrb_q[0]) addr_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) addr_q[15:8] <= wdata_q[15:8];
      end else if (wr_idx == IDX_DATA) begin
        if (wstrb_q[0]) data_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) data_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // Command sequencer
  logic go_write;
  logic go_erase;
  logic go_erwr;
  logic go_fuse;

  assign go_write = cmd_ok && new_cmd == CMD_WRITE;
  assign go_erase = cmd_ok && new_cmd == CMD_ERASE && mark_q != '0;
  assign go_erwr  = cmd_ok && new_cmd == CMD_ERWR;
  assign go_fuse  = cmd_ok && new_cmd == CMD_FUSE && bus_from_debug;

  // Synchronous reset drops arr_active, which aborts the array operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      tgt_q   <= TGT_FLASH;
      erw_q   <= 1'b0;
      timer_q <= 16'h0000;
      cmd_q   <= CMD_NONE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go_write || go_fuse) begin
            state_q <= ST_PROG;
            timer_q <= WRITE_CYC - 16'h1;
            tgt_q   <= go_fuse ? TGT_FUSE : tgt_e'(reg_q);
            erw_q   <= 1'b0;
            cmd_q   <= new_cmd;
          end else if (go_erase || go_erwr) begin
            state_q <= ST_ERASE;
            timer_q <= ERASE_CYC - 16'h1;
            tgt_q   <= tgt_e'(reg_q);
            erw_q   <= go_erwr;
            cmd_q   <= new_cmd;
          end else if (cmd_ok && new_cmd == CMD_CLEAR) begin
            state_q <= ST_CLEAR;
            timer_q <= CLEAR_CYC - 16'h1;
            cmd_q   <= new_cmd;
          end else if (cmd_ok && new_cmd == CMD_CHIP) begin
            state_q <= ST_CHIP;
            timer_q <= ERASE_CYC - 16'h1;
            tgt_q   <= TGT_FLASH;
            cmd_q   <= new_cmd;
          end else if (cmd_ok && new_cmd == CMD_EEALL) begin
            state_q <= ST_EEALL;
            timer_q <= ERASE_CYC - 16'h1;
            tgt_q   <= TGT_EE;
            cmd_q   <= new_cmd;
          end
        end
        ST_ERASE: begin
          if (timer_q != 16'h0000) begin
            timer_q <= timer_q - 16'h1;
          end else if (erw_q) begin
            state_q <= ST_PROG;
            timer_q <= WRITE_CYC - 16'h1;
            erw_q   <= 1'b0;
          end else begin
            state_q <= ST_IDLE;
            cmd_q   <= CMD_NONE;
          end
        end
        ST_PROG, ST_CLEAR, ST_CHIP, ST_EEALL: begin
          if (timer_q != 16'h0000) begin
            timer_q <= timer_q - 16'h1;
          end else begin
            state_q <= ST_IDLE;
            cmd_q   <= CMD_NONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // The buffer is kept across the erase half of an erase-write
  assign pb_clr = (timer_q == 16'h0000) && !erw_q &&
                  (state_q == ST_PROG || state_q == ST_ERASE ||
                   state_q == ST_CLEAR);

  // Write error is set by a refused store or CPU fuse command and cleared only by an accepted command; a refused access
  // in the cycle of an accepted command still sets it, so none is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrerr_q <= 1'b0;
    end else if (mem_valid && mem_write && !mem_wait &&
                 (t_flash || t_ee || t_user) && !store_ok) begin
      wrerr_q <= 1'b1;
    end else if (ctrla_wr && new_cmd == CMD_FUSE && !bus_from_debug) begin
      wrerr_q <= 1'b1;
    end else if (cmd_ok) begin
      wrerr_q <= 1'b0;
    end
  end

  logic f_busy;
  logic e_busy;

  assign f_busy = (state_q == ST_ERASE || state_q == ST_PROG) &&
                  (tgt_q == TGT_FLASH || tgt_q == TGT_FUSE) ||
                  state_q == ST_CHIP;
  assign e_busy = (state_q == ST_ERASE || state_q == ST_PROG) &&
                  (tgt_q == TGT_EE || tgt_q == TGT_USER) ||
                  state_q == ST_EEALL ||
                  (state_q == ST_CHIP && !ee_keep_q);

  // EEPROM and user-row page work lets the CPU run; everything else halts it
  assign cpu_halt = f_busy || state_q == ST_EEALL || state_q == ST_CHIP ||
                    state_q == ST_CLEAR;

  // Array strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arr_start      <= 1'b0;
      arr_erase      <= 1'b0;
      arr_program    <= 1'b0;
      arr_whole      <= 1'b0;
      arr_keep_ee    <= 1'b0;
      arr_target     <= 2'(TGT_FLASH);
      arr_page       <= 16'h0000;
      fuse_wr_strobe <= 1'b0;
      fuse_wr_addr   <= 16'h0000;
      fuse_wr_data   <= 8'h00;
    end else begin
      arr_start      <= (go_write && !go_fuse) || go_erase || go_erwr ||
                        (cmd_ok && (new_cmd == CMD_CHIP ||
                                    new_cmd == CMD_EEALL)) ||
                        (state_q == ST_ERASE && erw_q &&
                         timer_q == 16'h0000);
      fuse_wr_strobe <= go_fuse;
      if (go_fuse) begin
        fuse_wr_addr <= addr_q;
        fuse_wr_data <= data_q[7:0];
      end
      if (!busy && cmd_ok) begin
        arr_erase   <= new_cmd != CMD_WRITE;
        arr_program <= new_cmd == CMD_WRITE;
        arr_whole   <= new_cmd == CMD_CHIP || new_cmd == CMD_EEALL;
        arr_keep_ee <= new_cmd == CMD_CHIP && ee_keep_q;
        arr_target  <= new_cmd == CMD_EEALL ? 2'(TGT_EE) : reg_q;
        arr_page    <= page_q;
      end else if (state_q == ST_ERASE && erw_q && timer_q == 16'h0000) begin
        arr_erase   <= 1'b0;
        arr_program <= 1'b1;
      end
    end
  end

  assign arr_active = state_q == ST_ERASE || state_q == ST_PROG ||
                      state_q == ST_CHIP || state_q == ST_EEALL;

  // AXI4-Lite write channels
  assign awready = !aw_q && !bvalid;
  assign wready  = !w_q && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_q     <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go) begin
        aw_q   <= 1'b0;
        w_q    <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= reg_known(awaddr_q) ? RESP_OKAY : RESP_SLV;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  function automatic logic reg_known(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    if (a[11:10] != 2'h0) reg_known = 1'b0;
    else if (i == IDX_CTRLA || i == IDX_CTRLB || i == IDX_STATUS) reg_known = 1'b1;
    else if (i == IDX_INTCTL || i == IDX_INTFLG) reg_known = 1'b1;
    else if (i == IDX_DATA || i == IDX_ADDR || i == IDX_KEY) reg_known = 1'b1;
    else reg_known = 1'b0;
  endfunction

  // AXI4-Lite read channel
  logic [31:0] rd_val;
  logic [7:0]  rd_idx;

  assign arready = !rvalid;
  assign rd_idx  = araddr[9:2];

  always_comb begin
    rd_val = 32'h00000000;
    if (araddr[11:10] != 2'h0) begin
      rd_val = 32'h00000000;
    end else if (rd_idx == IDX_CTRLA) begin
      rd_val[2:0] = cmd_q;
    end else if (rd_idx == IDX_CTRLB) begin
      rd_val[CB_APP_CODE_WRITE_PROTECT] = app_code_write_protect_q;
      rd_val[CB_BLOCK] = block_q;
    end else if (rd_idx == IDX_STATUS) begin
      rd_val[ST_FBUSY]  = f_busy;
      rd_val[ST_EEBUSY] = e_busy;
      rd_val[ST_WRERR]  = wrerr_q;
    end else if (rd_idx == IDX_DATA) begin
      rd_val[15:0] = data_q;
    end else if (rd_idx == IDX_ADDR) begin
      rd_val[15:0] = addr_q;
    end else if (rd_idx == IDX_KEY) begin
      rd_val[KEY_FLAG] = win_q != 3'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= reg_known(araddr) ? RESP_OKAY : RESP_SLV;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // nvm_page_program_controller

// ### verilog/nvm_pkg.sv
/*
 Constants, types and register indices of the NVM page program controller.
 Assumes a 40 MHz aclk and registers reached over AXI4-Lite at 4*index.
*/
// How it works
// - Flash sections in 256-byte blocks from fuses
// - App-end zero extends code section to end
// - Both fuses zero: whole Flash is boot
// - Boot writes code/data; code writes data only
// - Protect and lock bits hold until reset
// - CPU never writes boot; lock hides reads
// - EEPROM touches only bytes marked in buffer
// - User row survives chip erase, debug-writable
// - Array reads stall while operation runs
// - Stores AND into one shared page buffer
// - Buffer all ones after reset, page ops, clear, wake
// - Page write: Flash halts CPU, then clear
// - Page erase needs a marked byte first
// - EEPROM page erase: marked bytes, CPU runs
// - Erase-write keeps buffer between two steps
// - Buffer clear halts CPU seven cycles
// - Chip erase; EEPROM kept when fuse set
// - EEPROM erase sets all ones, CPU halted
// - Fuse write only from debug port
// - Reset aborts any running operation
// - Three-bit command field decode
// - Key 0x9D unlocks the command field
package nvm_pkg;
  localparam int unsigned CLK_MHZ    = 40;
  localparam int unsigned ERASE_NS   = 4000;
  localparam int unsigned WRITE_NS   = 2000;
  localparam logic [15:0] ERASE_CYC  = 16'((ERASE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] WRITE_CYC  = 16'((WRITE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CLEAR_CYC  = 16'h0007;
  localparam int unsigned PB_BYTES   = 64;
  localparam int unsigned PB_W       = 6;
  localparam int unsigned BLOCK_SH   = 8;
  localparam logic [15:0] FLASH_BASE = 16'h8000;
  localparam logic [15:0] FLASH_SIZE = 16'h2000;
  localparam logic [15:0] EE_BASE    = 16'h1400;
  localparam logic [15:0] EE_SIZE    = 16'h0080;
  localparam logic [15:0] USER_BASE  = 16'h1300;
  localparam logic [15:0] USER_SIZE  = 16'h0020;
  localparam logic [7:0]  IDX_CTRLA  = 8'h00;
  localparam logic [7:0]  IDX_CTRLB  = 8'h01;
  localparam logic [7:0]  IDX_STATUS = 8'h02;
  localparam logic [7:0]  IDX_INTCTL = 8'h03;
  localparam logic [7:0]  IDX_INTFLG = 8'h04;
  localparam logic [7:0]  IDX_DATA   = 8'h06;
  localparam logic [7:0]  IDX_ADDR   = 8'h08;
  localparam logic [7:0]  IDX_KEY    = 8'h0A;
  localparam logic [7:0]  UNLOCK_KEY = 8'h9D;
  localparam logic [2:0]  KEY_WINDOW = 3'h4;
  localparam logic [2:0]  CMD_NONE   = 3'h0;
  localparam logic [2:0]  CMD_WRITE  = 3'h1;
  localparam logic [2:0]  CMD_ERASE  = 3'h2;
  localparam logic [2:0]  CMD_ERWR   = 3'h3;
  localparam logic [2:0]  CMD_CLEAR  = 3'h4;
  localparam logic [2:0]  CMD_CHIP   = 3'h5;
  localparam logic [2:0]  CMD_EEALL  = 3'h6;
  localparam logic [2:0]  CMD_FUSE   = 3'h7;
  localparam int unsigned CB_APP_CODE_WRITE_PROTECT   = 0;
  localparam int unsigned CB_BLOCK   = 1;
  localparam int unsigned ST_FBUSY   = 0;
  localparam int unsigned ST_EEBUSY  = 1;
  localparam int unsigned ST_WRERR   = 2;
  localparam int unsigned KEY_FLAG   = 1;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  typedef enum logic [1:0] {SEC_BOOT, SEC_CODE, SEC_DATA} sect_e;
  typedef enum logic [1:0] {TGT_FLASH, TGT_EE, TGT_USER, TGT_FUSE} tgt_e;
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_CLEAR, ST_CHIP,
                            ST_EEALL} state_e;
endpackage

// ### tb/nvm_array_model.sv
/* Array model: byte read data that depends on every address bit.
   Assumes the controller samples it combinationally. */
module nvm_array_model (
  input  wire logic [15:0] addr,
  output logic      [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  assign rdata = addr[7:0] ^ addr[15:8];
endmodule // nvm_array_model

// ### tb/nvm_chk_sva.sv
/* Port checker of the NVM controller.
   Assumes binding onto the design top, one clock domain. */
module nvm_chk (
  input wire logic         aclk, aresetn, bvalid, bready, rvalid, rready, arvalid, arready,
  input wire logic         mem_valid, mem_write, mem_wait, cpu_halt, arr_active,
  input wire logic         fuse_wr_strobe, bus_from_debug,
  input wire logic [1:0]   bresp,
  input wire logic [31:0]  rdata,
  input wire logic [511:0] arr_data,
  input wire logic [63:0]  arr_mark
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  property p_wait; disable iff (!aresetn) mem_wait |-> mem_valid && (arr_active || cpu_halt);
  endproperty
  a_wait: assert property (p_wait) else $error("wait with no operation");
  property p_abort; $rose(aresetn) |-> !cpu_halt && !arr_active; endproperty
  a_abort: assert property (p_abort) else $error("operation survived reset");
  property p_pb_rst; $rose(aresetn) |-> (&arr_data) && arr_mark == 64'h0; endproperty
  a_pb_rst: assert property (p_pb_rst) else $error("buffer not ones at reset");
  property p_mark; disable iff (!aresetn)
    |(arr_mark & ~$past(arr_mark)) |-> $past(mem_valid) && $past(mem_write); endproperty
  a_mark: assert property (p_mark) else $error("mark without store");
  property p_fuse; disable iff (!aresetn) fuse_wr_strobe |-> $past(bus_from_debug); endproperty
  a_fuse: assert property (p_fuse) else $error("fuse write not from debug");
  property p_bhold; disable iff (!aresetn) bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; disable iff (!aresetn) rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_rans; disable iff (!aresetn) arvalid && arready |=> rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
endmodule // nvm_chk
bind nvm_page_program_controller nvm_chk chk_u (.*);

// ### tb/nvm_page_program_controller_tb_top.sv
/* Self-checking bench of the NVM controller with an array model.
   Assumes the package and the design are compiled first. */
module nvm_page_program_controller_tb_top import nvm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic bus_from_debug = '0, mem_from_debug = '0, device_locked = '0, cpu_instr_done = '0;
  logic mem_valid = '0, mem_write = '0, wake_up = '0, eeprom_keep_on_erase = '0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic [15:0] cpu_pc = '0, mem_addr = '0, fuse_wr_addr, arr_page, fa;
  logic [7:0] mem_wdata = '0, boot_end_fuse = '0, app_code_end_fuse = '0, arr_rdata, mem_rdata;
  logic [7:0] fuse_wr_data, v1, v2;
  logic awready, wready, bvalid, arready, rvalid, mem_wait, cpu_halt, arr_active, arr_start;
  logic fuse_wr_strobe, fetch_blocked, arr_erase, arr_program, arr_whole, arr_keep_ee;
  logic [1:0] bresp, rresp, arr_target, rr;
  logic [511:0] arr_data;
  logic [63:0] arr_mark;
  int error_cnt = 0, n_tests = 0, hc = 0, k, nw;
  nvm_page_program_controller dut_u (.*);
  nvm_array_model arr_u (.addr(mem_addr), .rdata(arr_rdata));
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (cpu_halt) hc <= hc + 1;
  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [11:0] a);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata; rr = rresp; rready <= 1'h0;
  endtask
  task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d);
    nw = 0;
    mem_valid <= 1'h1; mem_write <= w; mem_addr <= a; mem_wdata <= d;
    do begin
      @(posedge aclk);
      nw += mem_wait;
    end while (mem_wait);
    mem_valid <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic cmd(input logic [2:0] c);
    axw(12'({IDX_KEY, 2'h0}), {24'h0, UNLOCK_KEY});
    axw(12'h000, {29'h0, c});
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h1F5E));
    boot_end_fuse <= 8'($urandom_range(31, 1));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk("pb_ones", 1, &arr_data);
    for (int i = 0; i < 4; i++) begin
      k = i * 16 + $urandom_range(15, 0);
      v1 = $urandom;
      v2 = $urandom;
      mem(1'h1, EE_BASE + 16'(k), v1);
      mem(1'h1, EE_BASE + 16'(k), v2);
      chk("pb_byte", v1 & v2, arr_data[8*k +: 8]);
      chk("pb_mark", 1, arr_mark[k]);
    end
    // Key opened, then four instructions pass: window closed
    axw(12'({IDX_KEY, 2'h0}), {24'h0, UNLOCK_KEY});
    repeat (4) begin
      cpu_instr_done <= 1'h1;
      @(posedge aclk);
    end
    cpu_instr_done <= 1'h0;
    axw(12'h000, {29'h0, CMD_CLEAR});
    repeat (12) @(posedge aclk);
    chk("late_cmd", 0, hc);
    cmd(CMD_CLEAR);
    repeat (12) @(posedge aclk);
    chk("clr_halt", 7, hc);
    chk("clr_mark", 0, arr_mark);
    mem(1'h1, EE_BASE + 16'h5, 8'h3C);
    wake_up <= 1'h1;
    @(posedge aclk);
    wake_up <= 1'h0;
    @(posedge aclk);
    chk("wake_mark", 0, arr_mark);
    cmd(CMD_ERASE);
    chk("erase_nomark", 0, arr_active);
    mem(1'h1, EE_BASE + 16'h3, v1);
    cmd(CMD_WRITE);
    chk("ee_tgt", 1, arr_target);
    axr(12'h008);
    chk("ee_busy", 2, rd[1:0]);
    chk("ee_halt", 0, cpu_halt);
    mem(1'h0, EE_BASE + 16'h3, 8'h00);
    chk("ld_wait", 1, nw > 0);
    chk("ld_data", exp_rd(EE_BASE + 16'h3), mem_rdata);
    chk("wr_mark", 0, arr_mark);
    axr(12'h014);
    chk("unmapped", RESP_SLV, rr);
    fa = 16'($urandom);
    bus_from_debug <= 1'h1;
    axw(12'h020, {16'h0, fa});
    axw(12'h018, {24'h0, v2});
    axw(12'h000, {29'h0, CMD_FUSE});
    bus_from_debug <= 1'h0;
    @(posedge aclk);
    chk("fuse_addr", fa, fuse_wr_addr);
    chk("fuse_data", v2, fuse_wr_data);
    cmd(CMD_FUSE);
    axr(12'h008);
    chk("fuse_cpu", 1, rd[ST_WRERR]);
    mem(1'h1, EE_BASE + 16'h9, v2);
    cmd(CMD_ERWR);
    chk("erwr_run", 2'h2, {arr_active, cpu_halt});
    while (arr_active) @(posedge aclk);
    cmd(CMD_CHIP);
    chk("chip_halt", 1, cpu_halt);
    chk("chip_whole", 1, arr_whole);
    while (cpu_halt) @(posedge aclk);
    cmd(CMD_EEALL);
    chk("eeall_halt", 1, cpu_halt);
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk("rst_abort", 0, {arr_active, cpu_halt});
    complete_run;
  end
endmodule // nvm_page_program_controller_tb_top
